// *** hw/dac_trigger_status_pkg.sv ***
package dac_trigger_status_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] TRIGGER_ADDR = 8'h21;
  localparam logic [7:0] GENERAL_STATUS_ADDR = 8'h22;
  localparam logic [7:0] COMPARATOR_STATUS_ADDR = 8'h23;
  localparam logic [7:0] PMBUS_PAGE = 8'hFF;
  localparam logic [7:0] TRIGGER_CMD = 8'hE5;
  localparam logic [7:0] GENERAL_STATUS_CMD = 8'hE6;
  localparam logic [7:0] COMPARATOR_STATUS_CMD = 8'hE7;
  // ****************************************
  // Trigger register fields, channel 1 and channel 0 groups; protect trigger bit of the common trigger register
  // ****************************************
  localparam int CMP_CLEAR_1_BIT = 15;
  localparam int MARGIN_LOW_1_BIT = 14;
  localparam int MARGIN_HIGH_1_BIT = 13;
  localparam int WAVEGEN_RUN_1_BIT = 12;
  localparam int CMP_CLEAR_0_BIT = 3;
  localparam int MARGIN_LOW_0_BIT = 2;
  localparam int MARGIN_HIGH_0_BIT = 1;
  localparam int WAVEGEN_RUN_0_BIT = 0;
  localparam int PROTECT_TRIGGER_BIT = 3;
  // ****************************************
  // Status fields
  // ****************************************
  localparam int FACTORY_CRC_BIT = 15;
  localparam int USER_CRC_BIT = 14;
  localparam int BUSY_0_BIT = 12;
  localparam int BUSY_1_BIT = 9;
  localparam int PROTECT_FLAG_BIT = 8;
  localparam int WIN_CMP_0_BIT = 7;
  localparam int WIN_CMP_1_BIT = 4;
  localparam int CMP_SYNC_0_BIT = 3;
  localparam int CMP_SYNC_1_BIT = 0;
  // Arbitrary neutral identity values
  localparam logic [5:0] PART_IDENTIFIER = 6'h2A;
  localparam logic [1:0] REVISION_IDENTIFIER = 2'h1;
  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage : dac_trigger_status_pkg

// *** hw/cmp_sync.sv ***
`timescale 1ns/1ps
module cmp_sync (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : cmp_sync

// *** hw/dac_trigger_status_regs.sv ***
`timescale 1ns/1ps
// How it works
// - Clear-flag write clears channel comparator latches
// - Margin-low write pulses command, self-clears
// - Margin-high write pulses command, self-clears
// - Wavegen run bit stored, drives generator
// - Middle trigger bits ignored, read zero
// - Factory CRC error sticky until reset
// - User CRC error sticky until reset
// - Channel 0 busy shown in status
// - Channel 1 busy shown in status
// - Part and revision identifiers in status
// - Protect flag set, cleared by read
// - Window result latched or passed per enable
// - Comparator flags synchronized into clock domain
// - General status at 22h or E6h
// - Comparator status at 23h or E7h
// - Protect trigger write starts protect function
// - Trigger register at 21h or E5h
module dac_trigger_status_regs (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic pmbus_mode,
  input wire logic [7:0] pmbus_page,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic common_trigger_write,
  input wire logic [15:0] common_trigger_wdata,
  input wire logic window_latch_enable,
  input wire logic [1:0] window_cmp_in,
  input wire logic [1:0] cmp_in,
  input wire logic [1:0] channel_busy,
  input wire logic factory_load_fail,
  input wire logic user_load_fail,
  input wire logic protect_done,
  output logic [1:0] margin_low_trigger,
  output logic [1:0] margin_high_trigger,
  output logic [1:0] cmp_flag_clear,
  output logic [1:0] wavegen_run,
  output logic protect_start,
  output logic [1:0] window_cmp_out,
  output logic [1:0] cmp_sync_out,
  output logic factory_load_crc_error,
  output logic user_load_crc_error
);
  // ****************************************
  // Address decode
  // ****************************************
  logic hit_trigger;
  logic hit_general;
  logic hit_compare;
  logic page_ok;
  logic [15:0] next_rdata;
  logic protect_flag;
  logic [1:0] window_latched;
  logic [1:0] window_sync;
  logic [1:0] unused_protect;

  assign page_ok = !pmbus_mode || (pmbus_page == dac_trigger_status_pkg::PMBUS_PAGE);
  assign hit_trigger = page_ok && (reg_addr == (pmbus_mode ? dac_trigger_status_pkg::TRIGGER_CMD
                       : dac_trigger_status_pkg::TRIGGER_ADDR));
  assign hit_general = page_ok && (reg_addr == (pmbus_mode
                       ? dac_trigger_status_pkg::GENERAL_STATUS_CMD
                       : dac_trigger_status_pkg::GENERAL_STATUS_ADDR));
  assign hit_compare = page_ok && (reg_addr == (pmbus_mode
                       ? dac_trigger_status_pkg::COMPARATOR_STATUS_CMD
                       : dac_trigger_status_pkg::COMPARATOR_STATUS_ADDR));
  assign unused_protect = 2'h0;

  // ****************************************
  // Trigger register
  // ****************************************
  // Self-clearing bits exist only as one-cycle pulses; they always read zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      margin_low_trigger <= 2'h0;
      margin_high_trigger <= 2'h0;
      cmp_flag_clear <= 2'h0;
    end else begin
      margin_low_trigger <= {2{reg_write && hit_trigger}} & {
        reg_wdata[dac_trigger_status_pkg::MARGIN_LOW_1_BIT],
        reg_wdata[dac_trigger_status_pkg::MARGIN_LOW_0_BIT]};
      margin_high_trigger <= {2{reg_write && hit_trigger}} & {
        reg_wdata[dac_trigger_status_pkg::MARGIN_HIGH_1_BIT],
        reg_wdata[dac_trigger_status_pkg::MARGIN_HIGH_0_BIT]};
      cmp_flag_clear <= {2{reg_write && hit_trigger}} & {
        reg_wdata[dac_trigger_status_pkg::CMP_CLEAR_1_BIT],
        reg_wdata[dac_trigger_status_pkg::CMP_CLEAR_0_BIT]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wavegen_run <= 2'h0;
    end else if (reg_write && hit_trigger) begin
      wavegen_run <= {reg_wdata[dac_trigger_status_pkg::WAVEGEN_RUN_1_BIT],
                      reg_wdata[dac_trigger_status_pkg::WAVEGEN_RUN_0_BIT]};
    end
  end

  // Protect trigger comes from the neighbouring common trigger register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      protect_start <= 1'b0;
    end else begin
      protect_start <= common_trigger_write
                       && common_trigger_wdata[dac_trigger_status_pkg::PROTECT_TRIGGER_BIT];
    end
  end

  // ****************************************
  // Sticky status flags
  // ****************************************
  // Only reset clears these; no write path reaches them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      factory_load_crc_error <= 1'b0;
      user_load_crc_error <= 1'b0;
    end else begin
      factory_load_crc_error <= factory_load_crc_error || factory_load_fail;
      user_load_crc_error <= user_load_crc_error || user_load_fail;
    end
  end

  // Set wins over read clear so a completion is never lost
  always_ff @(posedge core_clk) begin
    if (reset) begin
      protect_flag <= 1'b0;
    end else if (protect_start || protect_done) begin
      protect_flag <= 1'b1;
    end else if (reg_read && hit_compare) begin
      protect_flag <= 1'b0;
    end
  end

  // ****************************************
  // Comparators
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_sync
      cmp_sync u_cmp (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(cmp_in[ch]),
        .sync_out(cmp_sync_out[ch])
      );
      cmp_sync u_win (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(window_cmp_in[ch]),
        .sync_out(window_sync[ch])
      );
    end
  endgenerate

  // Clear wins over a new trip in the same cycle, as the host asked for it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      window_latched <= 2'h0;
    end else begin
      window_latched <= (window_latched | window_sync) & ~cmp_flag_clear;
    end
  end

  assign window_cmp_out = window_latch_enable ? window_latched : window_sync;

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    next_rdata = 16'h0000;
    if (hit_trigger) begin
      next_rdata[dac_trigger_status_pkg::WAVEGEN_RUN_1_BIT] = wavegen_run[1];
      next_rdata[dac_trigger_status_pkg::WAVEGEN_RUN_0_BIT] = wavegen_run[0];
    end else if (hit_general) begin
      next_rdata[dac_trigger_status_pkg::FACTORY_CRC_BIT] = factory_load_crc_error;
      next_rdata[dac_trigger_status_pkg::USER_CRC_BIT] = user_load_crc_error;
      next_rdata[dac_trigger_status_pkg::BUSY_0_BIT] = channel_busy[0];
      next_rdata[dac_trigger_status_pkg::BUSY_1_BIT] = channel_busy[1];
      next_rdata[7:0] = {dac_trigger_status_pkg::PART_IDENTIFIER,
                         dac_trigger_status_pkg::REVISION_IDENTIFIER};
    end else if (hit_compare) begin
      next_rdata[dac_trigger_status_pkg::PROTECT_FLAG_BIT] = protect_flag;
      next_rdata[dac_trigger_status_pkg::WIN_CMP_0_BIT] = window_cmp_out[0];
      next_rdata[dac_trigger_status_pkg::WIN_CMP_1_BIT] = window_cmp_out[1];
      next_rdata[dac_trigger_status_pkg::CMP_SYNC_0_BIT] = cmp_sync_out[0];
      next_rdata[dac_trigger_status_pkg::CMP_SYNC_1_BIT] = cmp_sync_out[1];
    end
    next_rdata[2:1] = next_rdata[2:1] | unused_protect;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= dac_trigger_status_pkg::REG_RESET;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  margin_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    (reg_write && hit_trigger && reg_wdata[dac_trigger_status_pkg::MARGIN_LOW_0_BIT])
    |=> margin_low_trigger[0] ##1 !margin_low_trigger[0] || $past(reg_write))
    else $error("margin low pulse wrong");
  margin_high_a: assert property (@(posedge core_clk) disable iff (reset)
    margin_high_trigger[1] |-> $past(reg_write && hit_trigger && reg_wdata[13]))
    else $error("margin high without write");
  clear_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    cmp_flag_clear[0] |=> !window_latched[0])
    else $error("window latch not cleared");
  run_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !(reg_write && hit_trigger) |=> $stable(wavegen_run))
    else $error("wavegen run changed without write");
  factory_sticky_a: assert property (@(posedge core_clk) disable iff (reset)
    factory_load_crc_error |=> factory_load_crc_error)
    else $error("factory crc error dropped");
  user_sticky_a: assert property (@(posedge core_clk) disable iff (reset)
    user_load_fail |=> user_load_crc_error [*2])
    else $error("user crc error not held");
  protect_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    (reg_read && hit_compare && !protect_start && !protect_done) |=> !protect_flag)
    else $error("protect flag not cleared by read");
  protect_set_a: assert property (@(posedge core_clk) disable iff (reset)
    protect_start |=> protect_flag)
    else $error("protect flag not set");
  window_pass_a: assert property (@(posedge core_clk) disable iff (reset)
    !window_latch_enable |-> window_cmp_out == window_sync)
    else $error("unlatched window mismatch");
  cmp_delay_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(cmp_sync_out[0]) |-> $past(cmp_in[0], 2))
    else $error("comparator sync delay wrong");
  ident_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (reg_read && hit_general) |=> reg_rdata[7:0] == {dac_trigger_status_pkg::PART_IDENTIFIER,
      dac_trigger_status_pkg::REVISION_IDENTIFIER})
    else $error("identifier read wrong");
  busy_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (reg_read && hit_general) |=> reg_rdata[12] == $past(channel_busy[0])
      && reg_rdata[9] == $past(channel_busy[1]))
    else $error("busy read wrong");
endmodule : dac_trigger_status_regs

// *** test/host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Host side of the register strobe port
// ****************************************
module host_model (
  input wire logic core_clk,
  input wire logic [15:0] reg_rdata,
  output logic reg_write,
  output logic reg_read,
  output logic pmbus_mode,
  output logic [7:0] pmbus_page,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    pmbus_mode = 1'b0;
    pmbus_page = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  task automatic xfer(input logic wr, input logic pm, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge core_clk);
    reg_write <= wr;
    reg_read <= !wr;
    pmbus_mode <= pm;
    pmbus_page <= pm ? 8'hFF : 8'h00;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    // Stale data must not look valid once the strobe drops
    reg_wdata <= ~d;
    #1;
    q = reg_rdata;
  endtask : xfer
endmodule : host_model

// *** test/test_dac_trigger_status_regs.sv ***
`timescale 1ns/1ps
module test_dac_trigger_status_regs;
  localparam logic [15:0] ID_FIELD = {8'h00, dac_trigger_status_pkg::PART_IDENTIFIER,
                                      dac_trigger_status_pkg::REVISION_IDENTIFIER};
  logic core_clk, reset, reg_write, reg_read, pmbus_mode, window_latch_enable;
  logic common_trigger_write, factory_load_fail, user_load_fail, protect_done, protect_start;
  logic [7:0] pmbus_page, reg_addr;
  logic [15:0] reg_wdata, reg_rdata, common_trigger_wdata, w;
  logic [1:0] window_cmp_in, cmp_in, channel_busy, margin_low_trigger, margin_high_trigger;
  logic [1:0] cmp_flag_clear, wavegen_run, window_cmp_out, cmp_sync_out;
  logic factory_load_crc_error, user_load_crc_error;
  int failures = 0;
  int checks_done = 0;
  always #2.5 core_clk = ~core_clk;
  dac_trigger_status_regs u_dac_trigger_status_regs (.core_clk(core_clk), .reset(reset),
    .reg_write(reg_write), .reg_read(reg_read), .pmbus_mode(pmbus_mode),
    .pmbus_page(pmbus_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .common_trigger_write(common_trigger_write),
    .common_trigger_wdata(common_trigger_wdata), .window_latch_enable(window_latch_enable),
    .window_cmp_in(window_cmp_in), .cmp_in(cmp_in), .channel_busy(channel_busy),
    .factory_load_fail(factory_load_fail), .user_load_fail(user_load_fail),
    .protect_done(protect_done), .margin_low_trigger(margin_low_trigger),
    .margin_high_trigger(margin_high_trigger), .cmp_flag_clear(cmp_flag_clear),
    .wavegen_run(wavegen_run), .protect_start(protect_start),
    .window_cmp_out(window_cmp_out), .cmp_sync_out(cmp_sync_out),
    .factory_load_crc_error(factory_load_crc_error),
    .user_load_crc_error(user_load_crc_error));
  host_model u_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata),
    .reg_write(reg_write), .reg_read(reg_read), .pmbus_mode(pmbus_mode),
    .pmbus_page(pmbus_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic pm, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    u_host_model.xfer(1'b0, pm, a, 16'h0000, q);
    chk("reg_rdata", q, e);
  endtask : rd
  task automatic wr(input logic pm, input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    u_host_model.xfer(1'b1, pm, a, d, q);
  endtask : wr
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cycles
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(1'b0, 8'h21, 16'h0000);
    rd(1'b0, 8'h22, ID_FIELD);
    rd(1'b0, 8'h23, 16'h0000);
    $display("reset values done");
  endtask : t_reset
  task automatic t_trig;
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      // Busy stays low, so every command here is legal
      wr(i[0], i[0] ? 8'hE5 : 8'h21, w);
      chk("pulses", {8'h00, margin_low_trigger, margin_high_trigger, cmp_flag_clear,
          wavegen_run}, {8'h00, w[14], w[2], w[13], w[1], w[15], w[3], w[12], w[0]});
      wait_cycles(1);
      chk("pulses_after", {8'h00, margin_low_trigger, margin_high_trigger, cmp_flag_clear,
          wavegen_run}, {14'h0000, w[12], w[0]});
      rd(i[0], i[0] ? 8'hE5 : 8'h21, w & 16'h1001);
    end
    $display("trigger bits done");
  endtask : t_trig
  task automatic t_status;
    channel_busy <= 2'b11;
    factory_load_fail <= 1'b1;
    user_load_fail <= 1'b1;
    wait_cycles(1);
    factory_load_fail <= 1'b0;
    user_load_fail <= 1'b0;
    wait_cycles(2);
    chk("crc_flags", {factory_load_crc_error, user_load_crc_error}, 16'h0003);
    rd(1'b1, 8'hE6, ID_FIELD | 16'hD200);
    wr(1'b0, 8'h22, 16'h0000);
    rd(1'b0, 8'h22, ID_FIELD | 16'hD200);
    channel_busy <= 2'b00;
    rd(1'b0, 8'h22, ID_FIELD | 16'hC000);
    reset <= 1'b1;
    wait_cycles(2);
    reset <= 1'b0;
    rd(1'b0, 8'h22, ID_FIELD);
    $display("general status done");
  endtask : t_status
  task automatic t_cmp;
    window_latch_enable <= 1'b1;
    window_cmp_in <= 2'b01;
    cmp_in <= 2'b10;
    wait_cycles(4);
    window_cmp_in <= 2'b00;
    wait_cycles(4);
    chk("window_cmp_out", window_cmp_out, 16'h0001);
    chk("cmp_sync_out", cmp_sync_out, 16'h0002);
    rd(1'b1, 8'hE7, 16'h0081);
    wr(1'b0, 8'h23, 16'hFFFF);
    rd(1'b0, 8'h23, 16'h0081);
    wr(1'b0, 8'h21, 16'h0008);
    wait_cycles(2);
    chk("window_cleared", window_cmp_out, 16'h0000);
    window_latch_enable <= 1'b0;
    window_cmp_in <= 2'b10;
    cmp_in <= 2'b01;
    wait_cycles(4);
    chk("window_live", window_cmp_out, 16'h0002);
    chk("cmp_sync_out_0", cmp_sync_out, 16'h0001);
    window_cmp_in <= 2'b00;
    cmp_in <= 2'b00;
    wait_cycles(4);
    chk("window_live_low", window_cmp_out, 16'h0000);
    common_trigger_wdata <= 16'h0008;
    common_trigger_write <= 1'b1;
    wait_cycles(1);
    common_trigger_write <= 1'b0;
    chk("protect_start", protect_start, 16'h0001);
    rd(1'b0, 8'h23, 16'h0100);
    rd(1'b0, 8'h23, 16'h0000);
    protect_done <= 1'b1;
    wait_cycles(1);
    protect_done <= 1'b0;
    rd(1'b0, 8'h23, 16'h0100);
    rd(1'b0, 8'h23, 16'h0000);
    $display("comparator status done");
  endtask : t_cmp
  initial begin
    #25000;
    failures++;
    wrap_up();
  end
  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    common_trigger_write = 1'b0;
    common_trigger_wdata = 16'h0000;
    window_latch_enable = 1'b0;
    window_cmp_in = 2'b00;
    cmp_in = 2'b00;
    channel_busy = 2'b00;
    factory_load_fail = 1'b0;
    user_load_fail = 1'b0;
    protect_done = 1'b0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_trig();
    t_status();
    t_cmp();
    wrap_up();
  end
endmodule : test_dac_trigger_status_regs
